// >>> ecc_mem_pkg.sv
// shared constants, check-bit code and state type for the ecc memory controller
package ecc_mem_pkg;
  // word layout
  localparam int data_width = 16;
  localparam int check_width = 6;
  localparam int word_width = 22;
  localparam int byte_width = 8;
  // clock rate
  localparam int clock_period_ns = 100;
  // refresh cycle length, longest time so rounded down
  localparam int refresh_cycle_max_ns = 725;
  localparam int refresh_cycles = refresh_cycle_max_ns / clock_period_ns;
  // refresh repetition limits
  localparam int refresh_typical_ns = 13300;
  localparam int refresh_fastest_ns = 11250;
  localparam int refresh_slowest_ns = 13750;
  localparam int refresh_fastest_cycles = (refresh_fastest_ns + clock_period_ns - 1) / clock_period_ns;
  localparam int refresh_slowest_cycles = refresh_slowest_ns / clock_period_ns;
  // worst wait of a pending refresh behind a running bus sequence
  localparam int longest_bus_cycles = 4;
  // period chosen so a delayed start still lands inside the slowest bound
  localparam int refresh_period_cycles = refresh_slowest_cycles - longest_bus_cycles;
  // access and cycle limits, the word ones checked at elaboration against the sequence lengths
  localparam int word_write_access_ns = 125;
  localparam int word_read_access_ns = 535;
  localparam int word_write_cycle_ns = 620;
  localparam int byte_write_cycle_ns = 1100;
  // pattern written by the power-up sweep
  localparam logic [15:0] init_data = 16'h0000;
  // check-bit column of every data bit, all of weight three
  localparam logic [5:0] data_column [0:15] = '{
    6'h07, 6'h0B, 6'h0D, 6'h0E, 6'h13, 6'h15, 6'h16, 6'h19,
    6'h1A, 6'h1C, 6'h23, 6'h25, 6'h26, 6'h29, 6'h2A, 6'h2C};

  // sequencer states
  typedef enum logic [3:0] {
    s_idle, s_write, s_read_fetch, s_read_check,
    s_rmw_fetch, s_rmw_check, s_rmw_write, s_refresh, s_init
  } state_type;

  // six check bits over sixteen data bits
  function automatic logic [5:0] encode(input logic [15:0] data);
    logic [5:0] check;
    check = 6'h00;
    for (int i = 0; i < data_width; i++) begin
      if (data[i]) begin
        check = check ^ data_column[i];
      end
    end
    return check;
  endfunction
endpackage

// >>> ecc_decoder.sv
// syndrome, error class and single-bit correction of one stored word
`timescale 1ns/10ps
module ecc_decoder (
  input wire logic clock,
  input wire logic srst,
  input wire logic [15:0] data_in,
  input wire logic [5:0] check_in,
  output logic [5:0] syndrome,
  output logic [15:0] corrected_data,
  output logic single_error,
  output logic double_error
);
  // fresh check bits against the stored ones
  assign syndrome = ecc_mem_pkg::encode(data_in) ^ check_in;
  // odd weight is one bit, even nonzero weight is two
  assign single_error = ^syndrome;
  assign double_error = (syndrome != 6'h00) && !(^syndrome);

  // flip the one data bit whose column matches; never on a double
  genvar i;
  for (i = 0; i < 16; i++) begin : g_fix
    assign corrected_data[i] = data_in[i] ^ (single_error && syndrome == ecc_mem_pkg::data_column[i]);
  end

  // a zero syndrome raises neither error class
  property p_class;
    @(posedge clock) disable iff (srst)
    (syndrome == 6'h00) |-> (!single_error && !double_error);
  endproperty
  a_class: assert property (p_class) else $error("clean word flagged as error");

  // a double error leaves the data untouched
  property p_no_double_fix;
    @(posedge clock) disable iff (srst)
    double_error |-> (corrected_data == data_in) && !single_error;
  endproperty
  a_no_double_fix: assert property (p_no_double_fix) else $error("double error was altered");

  // a corrected data bit gives a word consistent with its check bits
  property p_fix_ok;
    @(posedge clock) disable iff (srst)
    (single_error && corrected_data != data_in) |-> ecc_mem_pkg::encode(corrected_data) == check_in;
  endproperty
  a_fix_ok: assert property (p_fix_ok) else $error("single error correction wrong");
endmodule

// >>> refresh_timer.sv
// free-running interval timer that raises a refresh request
`timescale 1ns/10ps
module refresh_timer #(
  parameter int period_cycles = ecc_mem_pkg::refresh_period_cycles
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic refresh_ack,
  output logic refresh_req
);
  localparam int count_width = $clog2(period_cycles);
  // count must have room and a meaningful span
  if (period_cycles < 2) begin : g_bad_period
    $error("refresh period too short");
  end

  logic [count_width-1:0] count; // cycles to the next request
  logic next_expire; // request edge this cycle

  assign next_expire = (count == '0);

  // reload on expiry so request spacing is fixed
  always_ff @(posedge clock) begin
    if (srst) begin
      count <= count_width'(period_cycles - 1);
    end else if (next_expire) begin
      count <= count_width'(period_cycles - 1);
    end else begin
      count <= count - 1'b1;
    end
  end

  // sticky request, a new expiry wins over the acknowledge
  always_ff @(posedge clock) begin
    if (srst) begin
      refresh_req <= 1'b0;
    end else if (next_expire) begin
      refresh_req <= 1'b1;
    end else if (refresh_ack) begin
      refresh_req <= 1'b0;
    end
  end
endmodule

// >>> ecc_memory_write_refresh_ctrl.sv
// sequencer for word write, byte read-modify-write, read, refresh and power-up sweep
`timescale 1ns/10ps
// What this block does
// - word write stores data with fresh check bits
// - byte write done as read-modify-write
// - byte latched and ssyn raised before fetch
// - recompute check bits, compare, give syndrome
// - correct single data bit, never double
// - merge byte, regenerate check bits, write back
// - on double error rewrite old word unchanged
// - refresh cycle lasts at most 725 ns
// - one refresh every 11.25 to 13.75 us
// - busy drops when any sequence, refresh included, completes
// - power fail line drops after full sweep
// - ssyn ends every transfer
// - word write 125, read 535 ns access
// - word write cycle within 620 ns
// - sweep writes zero words, power fail held
// - syndrome weight classifies the error
module ecc_memory_write_refresh_ctrl #(
  parameter int addr_width = 19
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic msyn,
  input wire logic xfer_write,
  input wire logic xfer_byte,
  input wire logic byte_high,
  input wire logic [addr_width-1:0] word_addr,
  input wire logic [15:0] bus_data_in,
  input wire logic supply_low_in,
  output logic ssyn,
  output logic [15:0] bus_data_out,
  output logic power_fail_line,
  output logic array_busy,
  output logic refresh_active,
  output logic rmw_double_error
);
  localparam int count_width = $clog2(ecc_mem_pkg::refresh_cycles + 1);
  localparam int depth = 1 << addr_width;

  // address width the array can hold
  if (addr_width < 1 || addr_width > 22) begin : g_bad_width
    $error("addr_width out of range");
  end
  // sequence lengths must meet the access and cycle limits
  if (2 * ecc_mem_pkg::clock_period_ns > ecc_mem_pkg::word_write_cycle_ns ||
      ecc_mem_pkg::clock_period_ns > ecc_mem_pkg::word_write_access_ns ||
      3 * ecc_mem_pkg::clock_period_ns > ecc_mem_pkg::word_read_access_ns) begin : g_bad_timing
    $error("clock too slow for access limits");
  end

  ecc_mem_pkg::state_type state, next_state; // sequencer
  logic [21:0] mem [0:depth-1]; // storage array, check bits on top
  logic [addr_width-1:0] addr_q; // latched word address
  logic [addr_width-1:0] init_addr; // sweep pointer
  logic [15:0] data_q; // latched bus data
  logic high_q; // latched byte lane
  logic [21:0] fetched; // word read from the array
  logic [count_width-1:0] ref_count; // cycles spent in refresh
  logic refresh_req; // pending refresh from the timer
  logic [5:0] syndrome; // compare result
  logic [15:0] corrected; // data after correction
  logic single_err; // odd syndrome
  logic double_err; // even nonzero syndrome

  // arbitration: refresh first, then sweep, then a fresh bus request
  logic ref_start, init_go, take;
  assign ref_start = (state == ecc_mem_pkg::s_idle) && refresh_req;
  assign init_go = (state == ecc_mem_pkg::s_idle) && !refresh_req && power_fail_line && !supply_low_in;
  assign take = (state == ecc_mem_pkg::s_idle) && !refresh_req && !power_fail_line && msyn && !ssyn;

  // refresh interval source
  refresh_timer #(
    .period_cycles(ecc_mem_pkg::refresh_period_cycles)
  ) u_timer (
    .clock(clock),
    .srst(srst),
    .refresh_ack(ref_start),
    .refresh_req(refresh_req)
  );

  // syndrome and correction of the fetched word
  ecc_decoder u_decode (
    .clock(clock),
    .srst(srst),
    .data_in(fetched[15:0]),
    .check_in(fetched[21:16]),
    .syndrome(syndrome),
    .corrected_data(corrected),
    .single_error(single_err),
    .double_error(double_err)
  );

  // merge new byte into the corrected old word
  logic [15:0] merged;
  logic [21:0] rmw_word, full_word, init_word;
  assign merged = high_q ? {data_q[15:8], corrected[7:0]} : {corrected[15:8], data_q[7:0]};
  // double error keeps the old word, the new byte is lost
  assign rmw_word = double_err ? fetched : {ecc_mem_pkg::encode(merged), merged};
  assign full_word = {ecc_mem_pkg::encode(data_q), data_q};
  assign init_word = {ecc_mem_pkg::encode(ecc_mem_pkg::init_data), ecc_mem_pkg::init_data};

  // array write port selection
  logic mem_we;
  logic [addr_width-1:0] mem_waddr;
  logic [21:0] mem_wdata;
  logic rmw_hold; // check state result carried to the write state
  logic [21:0] rmw_q;
  assign mem_we = (state == ecc_mem_pkg::s_write) || (state == ecc_mem_pkg::s_rmw_write) ||
                  (state == ecc_mem_pkg::s_init);
  assign mem_waddr = (state == ecc_mem_pkg::s_init) ? init_addr : addr_q;
  assign mem_wdata = (state == ecc_mem_pkg::s_init) ? init_word :
                     (state == ecc_mem_pkg::s_rmw_write) ? rmw_q : full_word;
  assign rmw_hold = (state == ecc_mem_pkg::s_rmw_check);

  // busy while any internal sequence runs
  assign array_busy = (state != ecc_mem_pkg::s_idle);
  assign refresh_active = (state == ecc_mem_pkg::s_refresh);

  // next state
  always_comb begin
    next_state = state;
    unique case (state)
      ecc_mem_pkg::s_idle: begin
        if (ref_start) begin
          next_state = ecc_mem_pkg::s_refresh;
        end else if (init_go) begin
          next_state = ecc_mem_pkg::s_init;
        end else if (take && xfer_write && xfer_byte) begin
          next_state = ecc_mem_pkg::s_rmw_fetch;
        end else if (take && xfer_write) begin
          next_state = ecc_mem_pkg::s_write;
        end else if (take) begin
          next_state = ecc_mem_pkg::s_read_fetch;
        end
      end
      ecc_mem_pkg::s_write: next_state = ecc_mem_pkg::s_idle;
      ecc_mem_pkg::s_read_fetch: next_state = ecc_mem_pkg::s_read_check;
      ecc_mem_pkg::s_read_check: next_state = ecc_mem_pkg::s_idle;
      ecc_mem_pkg::s_rmw_fetch: next_state = ecc_mem_pkg::s_rmw_check;
      ecc_mem_pkg::s_rmw_check: next_state = ecc_mem_pkg::s_rmw_write;
      ecc_mem_pkg::s_rmw_write: next_state = ecc_mem_pkg::s_idle;
      ecc_mem_pkg::s_refresh: begin
        // leave only after the full refresh length
        if (ref_count == count_width'(ecc_mem_pkg::refresh_cycles - 1)) begin
          next_state = ecc_mem_pkg::s_idle;
        end
      end
      ecc_mem_pkg::s_init: begin
        // pause for supply loss, refresh or sweep end
        if (supply_low_in || refresh_req || init_addr == '1) begin
          next_state = ecc_mem_pkg::s_idle;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clock) begin
    if (srst) begin
      state <= ecc_mem_pkg::s_idle;
    end else begin
      state <= next_state;
    end
  end

  // latch address, byte lane and data at the request
  always_ff @(posedge clock) begin
    if (srst) begin
      addr_q <= '0;
      data_q <= 16'h0000;
      high_q <= 1'b0;
    end else if (take) begin
      addr_q <= word_addr;
      data_q <= bus_data_in;
      high_q <= byte_high;
    end
  end

  // array write and registered fetch
  always_ff @(posedge clock) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
    fetched <= mem[addr_q];
  end

  // hold the write-back word and its error class
  always_ff @(posedge clock) begin
    if (srst) begin
      rmw_q <= '0;
      rmw_double_error <= 1'b0;
    end else if (rmw_hold) begin
      rmw_q <= rmw_word;
      rmw_double_error <= double_err;
    end
  end

  // read data to the bus, corrected
  always_ff @(posedge clock) begin
    if (srst) begin
      bus_data_out <= 16'h0000;
    end else if (state == ecc_mem_pkg::s_read_check) begin
      bus_data_out <= corrected;
    end
  end

  // slave sync: early for writes, after check for reads, drops with msyn
  always_ff @(posedge clock) begin
    if (srst) begin
      ssyn <= 1'b0;
    end else if (!msyn) begin
      ssyn <= 1'b0;
    end else if (take && xfer_write) begin
      ssyn <= 1'b1;
    end else if (state == ecc_mem_pkg::s_read_check) begin
      ssyn <= 1'b1;
    end
  end

  // refresh length counter
  always_ff @(posedge clock) begin
    if (srst || state != ecc_mem_pkg::s_refresh) begin
      ref_count <= '0;
    end else begin
      ref_count <= ref_count + 1'b1;
    end
  end

  // sweep pointer and power fail line
  always_ff @(posedge clock) begin
    if (srst || supply_low_in) begin
      init_addr <= '0;
      power_fail_line <= 1'b1;
    end else if (state == ecc_mem_pkg::s_init) begin
      init_addr <= init_addr + 1'b1;
      if (init_addr == '1) begin
        power_fail_line <= 1'b0;
      end
    end
  end

  // cycles since the last refresh start, for the starvation check
  logic [7:0] since_ref;
  always_ff @(posedge clock) begin
    if (srst || ref_start) begin
      since_ref <= 8'h00;
    end else if (since_ref != 8'hFF) begin
      since_ref <= since_ref + 1'b1;
    end
  end

  property p_word_write;
    @(posedge clock) disable iff (srst)
    (take && xfer_write && !xfer_byte) |=> ssyn && mem_we && mem_waddr == $past(word_addr) &&
      mem_wdata == {ecc_mem_pkg::encode($past(bus_data_in)), $past(bus_data_in)};
  endproperty
  a_word_write: assert property (p_word_write) else $error("word write not stored");

  property p_byte_first;
    @(posedge clock) disable iff (srst)
    (take && xfer_write && xfer_byte) |=> ssyn && state == ecc_mem_pkg::s_rmw_fetch;
  endproperty
  a_byte_first: assert property (p_byte_first) else $error("byte ssyn not before fetch");

  property p_rmw_order;
    @(posedge clock) disable iff (srst)
    state == ecc_mem_pkg::s_rmw_fetch |=> state == ecc_mem_pkg::s_rmw_check ##1 mem_we ##1 !array_busy;
  endproperty
  a_rmw_order: assert property (p_rmw_order) else $error("read-modify-write out of order");

  property p_merge;
    @(posedge clock) disable iff (srst)
    (rmw_hold && !double_err) |=> mem_wdata[21:16] == ecc_mem_pkg::encode(mem_wdata[15:0]) &&
      mem_wdata[15:0] == $past(merged);
  endproperty
  a_merge: assert property (p_merge) else $error("merged word wrong");

  property p_double_keep;
    @(posedge clock) disable iff (srst)
    (rmw_hold && double_err) |=> mem_we && mem_wdata == $past(fetched);
  endproperty
  a_double_keep: assert property (p_double_keep) else $error("double error word changed");

  property p_refresh_len;
    @(posedge clock) disable iff (srst)
    ref_start |=> refresh_active [*7] ##1 !refresh_active;
  endproperty
  a_refresh_len: assert property (p_refresh_len) else $error("refresh length wrong");

  property p_refresh_due;
    @(posedge clock) disable iff (srst)
    since_ref <= 8'(ecc_mem_pkg::refresh_slowest_cycles);
  endproperty
  a_refresh_due: assert property (p_refresh_due) else $error("refresh starved");

  property p_sweep_hold;
    @(posedge clock) disable iff (srst)
    (state == ecc_mem_pkg::s_init) |-> power_fail_line && mem_wdata == init_word;
  endproperty
  a_sweep_hold: assert property (p_sweep_hold) else $error("sweep state wrong");

  property p_read_answer;
    @(posedge clock) disable iff (srst)
    (take && !xfer_write) |-> ##3 ssyn;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read ssyn late");

  c_word: cover property (@(posedge clock) disable iff (srst) take && xfer_write && !xfer_byte);
  c_byte_double: cover property (@(posedge clock) disable iff (srst) rmw_hold && double_err);
  c_refresh: cover property (@(posedge clock) disable iff (srst) ref_start);
  c_sweep_done: cover property (@(posedge clock) disable iff (srst) $fell(power_fail_line));
endmodule

// >>> bus_master_model.sv
// bus master model driving the msyn/ssyn handshake of the memory controller
`timescale 1ns/10ps
module bus_master_model #(
  parameter int aw = 4
) (
  input wire logic clock,
  output logic msyn,
  output logic xfer_write,
  output logic xfer_byte,
  output logic byte_high,
  output logic [aw-1:0] word_addr,
  output logic [15:0] bus_data_in,
  input wire logic ssyn,
  input wire logic [15:0] bus_data_out
);
  // idle levels at time zero
  initial begin
    msyn = 1'b0;
    xfer_write = 1'b0;
    xfer_byte = 1'b0;
    byte_high = 1'b0;
    word_addr = '0;
    bus_data_in = 16'h0000;
  end

  // one transfer; acc_ns stays -1 when no answer came
  task automatic transfer(input logic wr, input logic byt, input logic hi, input logic [aw-1:0] addr,
    input logic [15:0] data, output logic [15:0] rdata, output int acc_ns);
    realtime t0;
    int n;
    acc_ns = -1;
    rdata = 16'h0000;
    @(negedge clock);
    xfer_write = wr;
    xfer_byte = byt;
    byte_high = hi;
    word_addr = addr;
    bus_data_in = data;
    msyn = 1'b1;
    t0 = $realtime;
    n = 0;
    // lines and msyn held until ssyn is sampled high
    while (n < 60 && acc_ns < 0) begin
      @(posedge clock);
      #1;
      if (ssyn === 1'b1) begin
        acc_ns = int'($realtime - 1.0 - t0);
      end
      n++;
    end
    // read data taken one edge after the edge that samples ssyn high
    @(posedge clock);
    rdata = bus_data_out;
    // release; released lines show the inverse of their last value
    @(negedge clock);
    msyn = 1'b0;
    xfer_write = ~wr;
    xfer_byte = ~byt;
    byte_high = ~hi;
    word_addr = ~addr;
    bus_data_in = ~data;
    n = 0;
    // next request only after ssyn is gone
    while (n < 60 && ssyn !== 1'b0) begin
      @(posedge clock);
      #1;
      n++;
    end
  endtask
endmodule

// >>> test_ecc_memory_write_refresh_ctrl.sv
// self-checking testbench of the ecc memory write and refresh controller
`timescale 1ns/10ps
module test_ecc_memory_write_refresh_ctrl;
  localparam int aw = 4;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic supply_low_in = 1'b0;
  logic msyn, xfer_write, xfer_byte, byte_high;
  logic [aw-1:0] word_addr;
  logic [15:0] bus_data_in, bus_data_out;
  logic ssyn, power_fail_line, array_busy, refresh_active, rmw_double_error;
  logic [15:0] rd;
  int acc, w, l, w2, l2, n;
  int num_errors = 0;
  int cmp_count = 0;

  // 10 mhz clock
  always #50 clock = ~clock;

  ecc_memory_write_refresh_ctrl #(.addr_width(aw)) dut_u (.clock(clock), .srst(srst), .msyn(msyn),
    .xfer_write(xfer_write), .xfer_byte(xfer_byte), .byte_high(byte_high), .word_addr(word_addr),
    .bus_data_in(bus_data_in), .supply_low_in(supply_low_in), .ssyn(ssyn), .bus_data_out(bus_data_out),
    .power_fail_line(power_fail_line), .array_busy(array_busy), .refresh_active(refresh_active),
    .rmw_double_error(rmw_double_error));

  bus_master_model #(.aw(aw)) master_u (.clock(clock), .msyn(msyn), .xfer_write(xfer_write),
    .xfer_byte(xfer_byte), .byte_high(byte_high), .word_addr(word_addr), .bus_data_in(bus_data_in),
    .ssyn(ssyn), .bus_data_out(bus_data_out));

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  // verdict and end of run
  task automatic complete_run;
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // waits for a refresh start, then counts its length
  task automatic refresh_edges(output int wait_n, output int len_n);
    wait_n = 0;
    len_n = 0;
    while (refresh_active !== 1'b1 && wait_n < 300) begin
      @(posedge clock);
      #1;
      wait_n++;
    end
    while (refresh_active === 1'b1 && len_n < 20) begin
      check(array_busy, 1'b1);
      @(posedge clock);
      #1;
      len_n++;
    end
  endtask

  // counts cycles until the power fail line drops
  task automatic sweep_len(output int cnt);
    cnt = 0;
    while (power_fail_line !== 1'b0 && cnt < 400) begin
      @(posedge clock);
      #1;
      cnt++;
    end
  endtask

  // full-word writes and read back, top address included
  task automatic test_word_write;
    refresh_edges(w, l);
    master_u.transfer(1'b1, 1'b0, 1'b0, 4'h3, 16'hA5C3, rd, acc);
    check(acc >= 0 && acc <= 125, 1'b1);
    check(array_busy, 1'b0);
    master_u.transfer(1'b1, 1'b0, 1'b0, 4'hF, 16'hFFFF, rd, acc);
    master_u.transfer(1'b0, 1'b0, 1'b0, 4'h3, 16'h0000, rd, acc);
    check(rd, 16'hA5C3);
    check(acc >= 0 && acc <= 535, 1'b1);
    master_u.transfer(1'b0, 1'b0, 1'b0, 4'hF, 16'h0000, rd, acc);
    check(rd, 16'hFFFF);
    master_u.transfer(1'b0, 1'b0, 1'b0, 4'h5, 16'h0000, rd, acc);
    check(rd, 16'h0000);
  endtask

  // byte writes back to back, merged into the stored word
  task automatic test_byte_write;
    refresh_edges(w, l);
    master_u.transfer(1'b1, 1'b0, 1'b0, 4'h7, 16'h1234, rd, acc);
    master_u.transfer(1'b1, 1'b1, 1'b1, 4'h7, 16'hAB00, rd, acc);
    check(acc >= 0, 1'b1);
    check(array_busy, 1'b1);
    master_u.transfer(1'b1, 1'b1, 1'b0, 4'h7, 16'h00CD, rd, acc);
    check(acc >= 0, 1'b1);
    n = 0;
    while (array_busy === 1'b1 && n < 20) begin
      @(posedge clock);
      #1;
      n++;
    end
    check(rmw_double_error, 1'b0);
    master_u.transfer(1'b0, 1'b0, 1'b0, 4'h7, 16'h0000, rd, acc);
    check(rd, 16'hABCD);
  endtask

  // refresh length and spacing of two starts
  task automatic test_refresh;
    refresh_edges(w, l);
    refresh_edges(w2, l2);
    check(l > 0 && l * 100 <= 725, 1'b1);
    check(w2 + l >= 113 && w2 + l <= 137, 1'b1);
  endtask

  // write issued just as a refresh starts waits for it
  task automatic test_refresh_collision;
    n = 0;
    while (refresh_active !== 1'b1 && n < 300) begin
      @(posedge clock);
      #1;
      n++;
    end
    master_u.transfer(1'b1, 1'b0, 1'b0, 4'h9, 16'h3C69, rd, acc);
    check(acc >= 400, 1'b1);
    master_u.transfer(1'b0, 1'b0, 1'b0, 4'h9, 16'h0000, rd, acc);
    check(rd, 16'h3C69);
  endtask

  // supply low restarts the sweep, which clears the array
  task automatic test_supply_low;
    master_u.transfer(1'b1, 1'b0, 1'b0, 4'h2, 16'h5555, rd, acc);
    @(negedge clock);
    supply_low_in = 1'b1;
    repeat (3) @(negedge clock);
    check(power_fail_line, 1'b1);
    supply_low_in = 1'b0;
    sweep_len(n);
    check(n >= 16 && n < 400, 1'b1);
    master_u.transfer(1'b0, 1'b0, 1'b0, 4'h2, 16'h0000, rd, acc);
    check(rd, 16'h0000);
  endtask

  // main sequence
  initial begin
    repeat (10) @(negedge clock);
    check(ssyn, 1'b0);
    check(power_fail_line, 1'b1);
    check(bus_data_out, 16'h0000);
    check(rmw_double_error, 1'b0);
    srst = 1'b0;
    sweep_len(n);
    check(n >= 16 && n < 400, 1'b1);
    test_word_write();
    test_byte_write();
    test_refresh();
    test_refresh_collision();
    test_supply_low();
    complete_run();
  end

  // watchdog against a hang
  initial begin
    #(30000 * 100);
    num_errors++;
    complete_run();
  end
endmodule
